// *** design/oprs_top.sv ***
// Output remap selectors for pins 8-21 behind an AXI4-Lite slave
`timescale 1ns/1ps
module oprs_top (
   input  wire logic        aclk,          // System clock, 20 MHz
   input  wire logic        aresetn,       // Sync reset, active low
   input  wire logic        pkg_64pin,     // Strap: 64-pin package
   input  wire logic [4:0]  s_awaddr,      // Write address
   input  wire logic        s_awvalid,     // Write address valid
   output logic             s_awready,     // Write address ready
   input  wire logic [31:0] s_wdata,       // Write data
   input  wire logic [3:0]  s_wstrb,       // Write byte strobes
   input  wire logic        s_wvalid,      // Write data valid
   output logic             s_wready,      // Write data ready
   output logic [1:0]       s_bresp,       // Write response
   output logic             s_bvalid,      // Write response valid
   input  wire logic        s_bready,      // Write response ready
   input  wire logic [4:0]  s_araddr,      // Read address
   input  wire logic        s_arvalid,     // Read address valid
   output logic             s_arready,     // Read address ready
   output logic [31:0]      s_rdata,       // Read data
   output logic [1:0]       s_rresp,       // Read response
   output logic             s_rvalid,      // Read data valid
   input  wire logic        s_rready,      // Read data ready
   input  wire logic [63:0] func_out,      // Peripheral output functions
   input  wire logic [63:0] func_valid,    // Function number exists
   output logic [13:0]      pin_out,       // Pins 8..21 levels
   output logic [13:0]      pin_oe_n       // Pins 8..21 enables, low
);
   localparam int SW = oprs_pkg::SEL_W;
   localparam int NR = oprs_pkg::NUM_REGS;

   // ==========================================================
   // Selector storage
   logic [SW-1:0] sel_reg  [oprs_pkg::NUM_PINS];
   logic [SW-1:0] sel_next [oprs_pkg::NUM_PINS];
   logic          pkg64_reg;
   logic          pkg64_next;
   logic [2:0]    strap_sync_reg;
   logic [2:0]    strap_sync_next;

   // ==========================================================
   // Bus state
   oprs_pkg::oprs_state_e wr_state_reg, wr_state_next;
   oprs_pkg::oprs_state_e rd_state_reg, rd_state_next;
   logic        aw_held_reg, aw_held_next;
   logic        w_held_reg,  w_held_next;
   logic [4:0]  awaddr_reg,  awaddr_next;
   logic [31:0] wdata_reg,   wdata_next;
   logic [3:0]  wstrb_reg,   wstrb_next;
   logic [1:0]  bresp_reg,   bresp_next;
   logic [31:0] rdata_reg,   rdata_next;
   logic [1:0]  rresp_reg,   rresp_next;
   logic        do_write;
   logic [4:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;

   // Decode an address into a register index, or none
   function automatic logic [3:0] reg_index(input logic [4:0] addr);
      logic [3:0] idx;
      idx = 4'hF;
      if (addr[1:0] == 2'h0 && addr <= oprs_pkg::OFS_PINS_20_21)
         idx = {1'b0, addr[4:2]};
      return idx;
   endfunction

   // Read value of one register, unused bits zero
   function automatic logic [15:0] reg_value(input logic [2:0] r,
         input logic [SW-1:0] ev, input logic [SW-1:0] od);
      logic [15:0] v;
      v = 16'h0000;
      v[oprs_pkg::EVEN_LSB +: SW] = ev;
      v[oprs_pkg::ODD_LSB +: SW]  = od;
      return v & oprs_pkg::IMPL_MASK;
   endfunction

   // Handshake outputs decoded from the channel states
   assign s_awready = (wr_state_reg == oprs_pkg::OPRS_IDLE) && !aw_held_reg;
   assign s_wready  = (wr_state_reg == oprs_pkg::OPRS_IDLE) && !w_held_reg;
   assign s_arready = (rd_state_reg == oprs_pkg::OPRS_IDLE);
   assign s_bvalid  = (wr_state_reg == oprs_pkg::OPRS_RESP);
   assign s_rvalid  = (rd_state_reg == oprs_pkg::OPRS_RESP);
   assign s_bresp   = bresp_reg;
   assign s_rresp   = rresp_reg;
   assign s_rdata   = rdata_reg;

   // Merge held and live write channels
   always_comb begin
      wr_addr  = aw_held_reg ? awaddr_reg : s_awaddr;
      wr_data  = w_held_reg ? wdata_reg : s_wdata;
      wr_strb  = w_held_reg ? wstrb_reg : s_wstrb;
      do_write = (wr_state_reg == oprs_pkg::OPRS_IDLE)
               && (aw_held_reg || s_awvalid) && (w_held_reg || s_wvalid);
   end

   // Write channel sequencing and selector updates
   always_comb begin
      logic [3:0] idx;
      idx           = reg_index(wr_addr);
      wr_state_next = wr_state_reg;
      aw_held_next  = aw_held_reg;
      w_held_next   = w_held_reg;
      awaddr_next   = awaddr_reg;
      wdata_next    = wdata_reg;
      wstrb_next    = wstrb_reg;
      bresp_next    = bresp_reg;
      for (int p = 0; p < oprs_pkg::NUM_PINS; p++) begin
         sel_next[p] = sel_reg[p];
      end
      if (s_awvalid && s_awready) begin
         aw_held_next = 1'b1;
         awaddr_next  = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         w_held_next = 1'b1;
         wdata_next  = s_wdata;
         wstrb_next  = s_wstrb;
      end
      // Idle commits a complete write, response waits for bready
      case (wr_state_reg)
         oprs_pkg::OPRS_IDLE: begin
            if (do_write) begin
               aw_held_next  = 1'b0;
               w_held_next   = 1'b0;
               wr_state_next = oprs_pkg::OPRS_RESP;
               bresp_next    = oprs_pkg::RESP_SLVERR;
               if (idx < 4'(NR)) begin
                  bresp_next = oprs_pkg::RESP_OKAY;
                  // Byte 0 carries even selector, byte 1 the odd one
                  if (wr_strb[0]) begin
                     sel_next[2*idx] =
                        wr_data[oprs_pkg::EVEN_LSB +: SW];
                  end
                  if (wr_strb[1]) begin
                     sel_next[2*idx+1] =
                        wr_data[oprs_pkg::ODD_LSB +: SW];
                  end
               end
            end
         end
         oprs_pkg::OPRS_RESP: begin
            if (s_bready) begin
               wr_state_next = oprs_pkg::OPRS_IDLE;
            end
         end
         default: begin
            wr_state_next = oprs_pkg::OPRS_IDLE;
         end
      endcase
      if (pkg64_reg) begin
         sel_next[oprs_pkg::PIN15_IDX] = oprs_pkg::SEL_RESET;
      end
   end

   // Register write side state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_reg <= oprs_pkg::OPRS_IDLE;
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         awaddr_reg   <= 5'h00;
         wdata_reg    <= 32'h00000000;
         wstrb_reg    <= 4'h0;
         bresp_reg    <= 2'h0;
         for (int p = 0; p < oprs_pkg::NUM_PINS; p++) begin
            sel_reg[p] <= oprs_pkg::SEL_RESET;
         end
      end else begin
         wr_state_reg <= wr_state_next;
         aw_held_reg  <= aw_held_next;
         w_held_reg   <= w_held_next;
         awaddr_reg   <= awaddr_next;
         wdata_reg    <= wdata_next;
         wstrb_reg    <= wstrb_next;
         bresp_reg    <= bresp_next;
         for (int p = 0; p < oprs_pkg::NUM_PINS; p++) begin
            sel_reg[p] <= sel_next[p];
         end
      end
   end

   // ==========================================================
   // Package strap synchroniser, three stages
   // A change counts once the second and third stages agree
   always_comb begin
      strap_sync_next = {strap_sync_reg[1:0], pkg_64pin};
      pkg64_next      = pkg64_reg;
      if (strap_sync_reg[2] == strap_sync_reg[1]) begin
         pkg64_next = strap_sync_reg[2];
      end
   end

   // Strap flops run through reset, variant known at release
   always_ff @(posedge aclk) begin
      strap_sync_reg <= strap_sync_next;
      pkg64_reg      <= pkg64_next;
   end

   // Read channel
   always_comb begin
      logic [3:0]  idx;
      logic [15:0] v;
      idx           = reg_index(s_araddr);
      v             = 16'h0000;
      rd_state_next = rd_state_reg;
      rdata_next    = rdata_reg;
      rresp_next    = rresp_reg;
      // Idle takes an address, response waits for rready
      case (rd_state_reg)
         oprs_pkg::OPRS_IDLE: begin
            if (s_arvalid && s_arready) begin
               rd_state_next = oprs_pkg::OPRS_RESP;
               rresp_next    = oprs_pkg::RESP_SLVERR;
               rdata_next    = 32'h00000000;
               if (idx < 4'(NR)) begin
                  v = reg_value(idx[2:0], sel_reg[2*idx], sel_reg[2*idx+1]);
                  rdata_next = {16'h0000, v};
                  rresp_next = oprs_pkg::RESP_OKAY;
               end
            end
         end
         oprs_pkg::OPRS_RESP: begin
            if (s_rready) begin
               rd_state_next = oprs_pkg::OPRS_IDLE;
            end
         end
         default: begin
            rd_state_next = oprs_pkg::OPRS_IDLE;
         end
      endcase
   end

   // Register read side state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_reg <= oprs_pkg::OPRS_IDLE;
         rdata_reg    <= 32'h00000000;
         rresp_reg    <= 2'h0;
      end else begin
         rd_state_reg <= rd_state_next;
         rdata_reg    <= rdata_next;
         rresp_reg    <= rresp_next;
      end
   end

   // ==========================================================
   // One multiplexer per remappable pin
   for (genvar p = 0; p < oprs_pkg::NUM_PINS; p++) begin : g_pin
      oprs_pin_mux u_mux (
         .aclk       (aclk),
         .aresetn    (aresetn),
         .sel        (sel_reg[p]),
         .func_out   (func_out),
         .func_valid (func_valid),
         .pin_out    (pin_out[p]),
         .pin_oe_n   (pin_oe_n[p])
      );
   end

   // ==========================================================
   // Checks
   a_read_reserved: assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_rvalid |-> (s_rdata & ~32'(oprs_pkg::IMPL_MASK)) == 32'h0)
      else $error("reserved bits read nonzero");
   a_even_write: assert property (@(posedge aclk)
      disable iff (!aresetn)
      do_write && reg_index(wr_addr) == 4'h0 && wr_strb[0]
      |=> sel_reg[0] == $past(wr_data[5:0]))
      else $error("even selector not written");
   a_odd_write: assert property (@(posedge aclk)
      disable iff (!aresetn)
      do_write && reg_index(wr_addr) == 4'h6 && wr_strb[1]
      |=> sel_reg[13] == $past(wr_data[13:8]))
      else $error("odd selector of last register not written");
   a_reset_zero: assert property (@(posedge aclk)
      !aresetn |=> sel_reg[0] == 6'h00 && sel_reg[13] == 6'h00)
      else $error("selector not cleared by reset");
   a_pin15_zero: assert property (@(posedge aclk)
      disable iff (!aresetn)
      pkg64_reg && $past(pkg64_reg) |-> sel_reg[7] == 6'h00)
      else $error("pin 15 selector set in 64-pin package");
   a_bad_addr: assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_arvalid && s_arready && reg_index(s_araddr) == 4'hF
      |=> s_rvalid && s_rresp == oprs_pkg::RESP_SLVERR)
      else $error("unmapped read not refused");
   a_read_back: assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_arvalid && s_arready && s_araddr == 5'h04
      |=> s_rdata[5:0] == $past(sel_reg[2]))
      else $error("read data mismatch");
   a_route_pin: assert property (@(posedge aclk)
      disable iff (!aresetn)
      func_valid[sel_reg[0]] |=> !pin_oe_n[0])
      else $error("pin 8 not driven by valid selection");
   a_write_answer: assert property (@(posedge aclk)
      disable iff (!aresetn)
      do_write |=> s_bvalid)
      else $error("write not answered");
   a_read_answer: assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_arvalid && s_arready |=> s_rvalid)
      else $error("read not answered");

   // Main scenarios: writes, reads, driven pins, small package
   c_write: cover property (@(posedge aclk) do_write);
   c_bad_write: cover property (@(posedge aclk)
      do_write && reg_index(wr_addr) == 4'hF);
   c_read: cover property (@(posedge aclk) s_rvalid && s_rready);
   c_driven: cover property (@(posedge aclk) !pin_oe_n[13]);
   c_pkg64: cover property (@(posedge aclk) pkg64_reg && s_rvalid);
endmodule

// *** design/oprs_pkg.sv ***
// Package with constants for the output pin remap selector block
// Contract
// - Two 6-bit selectors per 16-bit register
// - Bits 15-14 and 7-6 read zero, ignore writes
// - Selectors reset to zero, fully read/write
// - Selector value n routes peripheral output n
// - 64-pin variant: pin 15 selector reads zero
// - Seven registers cover pins 8 through 21
package oprs_pkg;
   // ==========================================================
   // Geometry
   localparam int NUM_REGS   = 7;
   localparam int NUM_PINS   = 14;
   localparam int FIRST_PIN  = 8;
   localparam int SEL_W      = 6;
   localparam int REG_W      = 16;
   localparam int NUM_FUNCS  = 64;
   // ==========================================================
   // Field layout
   localparam int EVEN_LSB   = 0;
   localparam int ODD_LSB    = 8;
   localparam logic [15:0] IMPL_MASK = 16'h3F3F;
   localparam logic [5:0]  SEL_RESET = 6'h00;
   // ==========================================================
   // Register map, byte addresses, one word each
   localparam logic [4:0] OFS_PINS_8_9   = 5'h00;
   localparam logic [4:0] OFS_PINS_20_21 = 5'h18;
   localparam logic [4:0] OFS_STRIDE     = 5'h04;
   localparam int PIN15_IDX = 15 - FIRST_PIN;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // Bus state
   typedef enum logic [0:0] {OPRS_IDLE, OPRS_RESP} oprs_state_e;
endpackage

// *** design/oprs_pin_mux.sv ***
// One remappable pin output multiplexer
`timescale 1ns/1ps
module oprs_pin_mux (
   input  wire logic                           aclk,       // System clock
   input  wire logic                           aresetn,    // Sync reset, low
   input  wire logic [oprs_pkg::SEL_W-1:0]     sel,        // Selector value
   input  wire logic [oprs_pkg::NUM_FUNCS-1:0] func_out,   // Function levels
   input  wire logic [oprs_pkg::NUM_FUNCS-1:0] func_valid, // Function exists
   output logic                                pin_out,    // Pin level
   output logic                                pin_oe_n    // Low drives pin
);
   logic pin_out_next;
   logic pin_oe_n_next;

   // Index the function list by the selector
   always_comb begin
      pin_out_next  = 1'b0;
      pin_oe_n_next = 1'b1;
      if (func_valid[sel]) begin
         pin_out_next  = func_out[sel];
         pin_oe_n_next = 1'b0;
      end
   end

   // Register pin outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out  <= 1'b0;
         pin_oe_n <= 1'b1;
      end else begin
         pin_out  <= pin_out_next;
         pin_oe_n <= pin_oe_n_next;
      end
   end

   a_unknown_undriven: assert property (@(posedge aclk)
      disable iff (!aresetn)
      !func_valid[sel] |=> pin_oe_n)
      else $error("pin driven by nonexistent function");
   a_route_value: assert property (@(posedge aclk)
      disable iff (!aresetn)
      func_valid[sel] |=> !pin_oe_n && pin_out == $past(func_out[sel]))
      else $error("pin not routed from selected function");
endmodule

// *** verification/oprs_tb_top.sv ***
// Self-checking bench for the output remap selectors over AXI4-Lite
`timescale 1ns/1ps
module output_pin_remap_selectors_tb_top;
   // ==========================================================
   // Stimulus and observation signals
   logic        aclk;
   logic        aresetn;
   logic        pkg_64pin;
   logic [4:0]  s_awaddr;
   logic        s_awvalid;
   logic        s_awready;
   logic [31:0] s_wdata;
   logic [3:0]  s_wstrb;
   logic        s_wvalid;
   logic        s_wready;
   logic [1:0]  s_bresp;
   logic        s_bvalid;
   logic        s_bready;
   logic [4:0]  s_araddr;
   logic        s_arvalid;
   logic        s_arready;
   logic [31:0] s_rdata;
   logic [1:0]  s_rresp;
   logic        s_rvalid;
   logic        s_rready;
   logic [63:0] func_out;
   logic [63:0] func_valid;
   logic [13:0] pin_out;
   logic [13:0] pin_oe_n;
   logic [5:0]  sel_m [14];
   logic [1:0]  rsp;
   int          error_cnt;
   int          num_checks;
   // ==========================================================
   // Device under test
   oprs_top dut_u (.aclk(aclk), .aresetn(aresetn), .pkg_64pin(pkg_64pin),
      .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
      .s_rvalid(s_rvalid), .s_rready(s_rready), .func_out(func_out),
      .func_valid(func_valid), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
   // ==========================================================
   // Clock, 50 ns period
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [63:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Verdict and end of run
   task automatic summarize;
      if (error_cnt == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ==========================================================
   // Bus master: write, both channels offered together
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
                         input logic [3:0] st, output logic [1:0] r);
      logic a_hs, w_hs, a_dn, w_dn;
      a_dn = 1'b0;
      w_dn = 1'b0;
      @(posedge aclk);
      s_awaddr <= a; s_awvalid <= 1'b1; s_wdata <= d;
      s_wstrb <= st; s_wvalid <= 1'b1; s_bready <= 1'b1;
      while (!(a_dn && w_dn)) begin
         @(negedge aclk);
         a_hs = s_awvalid & s_awready;
         w_hs = s_wvalid & s_wready;
         @(posedge aclk);
         if (a_hs) begin s_awvalid <= 1'b0; a_dn = 1'b1; end
         if (w_hs) begin s_wvalid <= 1'b0; w_dn = 1'b1; end
      end
      do @(negedge aclk); while (s_bvalid !== 1'b1);
      r = s_bresp;
      @(posedge aclk);
      s_bready <= 1'b0;
   endtask
   // Bus master: read, then compare data and response
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp,
                         input logic [1:0] er);
      logic hs;
      hs = 1'b0;
      @(posedge aclk);
      s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
      while (!hs) begin
         @(negedge aclk);
         hs = s_arvalid & s_arready;
         @(posedge aclk);
         if (hs) s_arvalid <= 1'b0;
      end
      do @(negedge aclk); while (s_rvalid !== 1'b1);
      chk("rdata", s_rdata, exp);
      chk("rresp", s_rresp, er);
      @(posedge aclk);
      s_rready <= 1'b0;
   endtask
   // Pin levels and enables against the selector model
   task automatic pins_chk;
      logic [5:0]  s;
      logic [13:0] eo, ee;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      for (int i = 0; i < 14; i++) begin
         s = (pkg_64pin && i == oprs_pkg::PIN15_IDX) ? 6'h00 : sel_m[i];
         eo[i] = func_valid[s] & func_out[s];
         ee[i] = ~func_valid[s];
      end
      chk("pin_out", pin_out, eo);
      chk("pin_oe_n", pin_oe_n, ee);
      @(posedge aclk);
   endtask
   // ==========================================================
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      summarize();
   end
   // Main sequence
   initial begin
      aresetn = 1'b0; pkg_64pin = 1'b0; s_awaddr = 5'h00; s_awvalid = 1'b0;
      s_wdata = 32'h0; s_wstrb = 4'h0; s_wvalid = 1'b0; s_bready = 1'b0;
      s_araddr = 5'h00; s_arvalid = 1'b0; s_rready = 1'b0;
      func_out = 64'hA5C3_0F96_5A3C_F069; func_valid = 64'h0;
      error_cnt = 0; num_checks = 0;
      foreach (sel_m[i]) sel_m[i] = 6'h00;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      pins_chk();
      // Reset values, then all ones keep only selector bits
      for (int k = 0; k < 7; k++) begin
         rd_chk(5'(k * 4), 32'h0, oprs_pkg::RESP_OKAY);
         axi_wr(5'(k * 4), 32'hFFFF_FFFF, 4'hF, rsp);
         chk("bresp", rsp, oprs_pkg::RESP_OKAY);
         rd_chk(5'(k * 4), 32'h3F3F, oprs_pkg::RESP_OKAY);
      end
      // Byte lanes reach one selector each
      axi_wr(5'h00, 32'h0, 4'h1, rsp);
      rd_chk(5'h00, 32'h3F00, oprs_pkg::RESP_OKAY);
      axi_wr(5'h00, 32'h2A15, 4'h2, rsp);
      rd_chk(5'h00, 32'h2A00, oprs_pkg::RESP_OKAY);
      // Distinct selectors, reserved bits set in the write data
      func_valid <= 64'hFFFF_FFFF_FFFF_FFFF;
      for (int k = 0; k < 7; k++) begin
         sel_m[2 * k] = 6'(18 * k + 5);
         sel_m[2 * k + 1] = 6'(18 * k + 14);
         axi_wr(5'(k * 4), {16'hFFFF, 2'b11, sel_m[2 * k + 1], 2'b11,
                sel_m[2 * k]}, 4'hF, rsp);
         rd_chk(5'(k * 4), {18'h0, sel_m[2 * k + 1], 2'b00, sel_m[2 * k]},
                oprs_pkg::RESP_OKAY);
      end
      pins_chk();
      // Selector naming a missing function leaves the pin undriven
      func_valid[sel_m[0]] <= 1'b0;
      func_valid[sel_m[9]] <= 1'b0;
      pins_chk();
      // Small package: pin 15 selector reads zero and cannot be set
      pkg_64pin <= 1'b1;
      func_valid[0] <= 1'b1;
      // Let the strap pass the synchroniser first
      repeat (4) @(posedge aclk);
      axi_wr(5'h0C, 32'h3F3F, 4'hF, rsp);
      sel_m[6] = 6'h3F;
      rd_chk(5'h0C, 32'h003F, oprs_pkg::RESP_OKAY);
      pins_chk();
      // Unmapped and misaligned places answer with an error
      axi_wr(5'h1C, 32'h3F3F, 4'hF, rsp);
      chk("bresp_unmapped", rsp, oprs_pkg::RESP_SLVERR);
      rd_chk(5'h1C, 32'h0, oprs_pkg::RESP_SLVERR);
      rd_chk(5'h02, 32'h0, oprs_pkg::RESP_SLVERR);
      rd_chk(5'h18, {18'h0, sel_m[13], 2'b00, sel_m[12]},
             oprs_pkg::RESP_OKAY);
      // Second reset in mid-run clears every selector
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (sel_m[i]) sel_m[i] = 6'h00;
      for (int k = 0; k < 7; k++)
         rd_chk(5'(k * 4), 32'h0, oprs_pkg::RESP_OKAY);
      pins_chk();
      summarize();
   end
endmodule
